// ==== logic/tmt_consts.svh ====
/*
  register offsets, field positions, reset values and widths of the
  timer trigger generation block.
  assumes it is included by bare name before any module that needs it.
*/
// Behaviour
// (RULE_01) channel trigger sets flag bit 7
// (RULE_02) flag clears after read-set then write-0
// (RULE_03) writing 1 to flag does nothing
// (RULE_04) new channel trigger aborts clearing sequence
// (RULE_05) bit 6 enables trigger on initial-value match
// (RULE_06) bit 5 enables channel 1 trigger
// (RULE_07) bit 3 enables channel 5 trigger
// (RULE_08) bit 2 enables channel 4 trigger
// (RULE_09) channels 0, 2, 3 enabled alike
// (RULE_10) bits 31-8 reserved, no effect
// (RULE_11) channels 6 and 7 never trigger
// (RULE_12) several enabled channels trigger independently
// (RULE_13) channel 0, 3, 2 enables: bits 4,1,0
// (RULE_14) each trigger is one-cycle output pulse
`ifndef TMT_CONSTS_SVH
`define TMT_CONSTS_SVH

// register byte offsets
`define TMT_OFF_TRIG      8'h6c
`define TMT_OFF_IRQ_STAT  8'h80
`define TMT_OFF_IRQ_CLR   8'h84
`define TMT_OFF_IRQ_EN    8'h88

// trigger register field positions
`define TMT_BIT_FLAG      7
`define TMT_BIT_INIT_EN   6
`define TMT_BIT_CH1_EN    5
`define TMT_BIT_CH0_EN    4
`define TMT_BIT_CH5_EN    3
`define TMT_BIT_CH4_EN    2
`define TMT_BIT_CH3_EN    1
`define TMT_BIT_CH2_EN    0

// interrupt status bit positions
`define TMT_IRQ_CHAN      0
`define TMT_IRQ_INIT      1

// reset values
`define TMT_RST_CTRL      7'h00
`define TMT_RST_IRQ       2'h0

// widths
`define TMT_ADDR_W        8
`define TMT_NUM_CHAN      8
`define TMT_TRIG_CHAN     6

`endif

// ==== logic/tmt_pkg.sv ====
/*
  types of the timer trigger generation block.
  assumes tmt_consts.svh is reachable on the include path.
*/
`default_nettype none
`include "tmt_consts.svh"
package tmt_pkg;

  // register bus request from the master
  typedef struct packed {
    logic [`TMT_ADDR_W-1:0] addr;  // byte address
    logic [31:0]            wdata; // write data
    logic                   wr;    // write strobe
    logic                   rd;    // read strobe
  } tmt_bus_req_s;

  // clearing sequence of the channel trigger flag
  typedef enum logic [0:0] {
    TMT_IDLE,
    TMT_ARMED
  } tmt_clr_state_e;

endpackage
`default_nettype wire

// ==== logic/tmt_edge_det.sv ====
/*
  rising edge detector for a vector of equality levels.
  assumes the levels are synchronous to clk_in.
*/
`default_nettype none
module tmt_edge_det #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // levels in, one-cycle rises out
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_out
);
  import tmt_pkg::*;

  logic [W-1:0] prev;      // level one cycle ago
  logic [W-1:0] next_prev; // next value of prev

  // a level held over many cycles yields only one rise
  always_comb
  begin
    next_prev = level_in;
    rise_out  = level_in & ~prev;
  end

  // history register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      prev <= '0;
    else
      prev <= next_prev;
  end
endmodule
`default_nettype wire

// ==== logic/tmt_trig_flag.sv ====
/*
  sticky channel trigger flag with its read-then-write-zero clear.
  assumes rd_in and wr_in are strobes aimed at the trigger register.
*/
`default_nettype none
module tmt_trig_flag (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // events
  input  wire logic set_in,
  input  wire logic rd_in,
  input  wire logic wr_in,
  input  wire logic wbit_in,
  // flag
  output logic      flag_out
);
  import tmt_pkg::*;

  tmt_clr_state_e state;      // clearing sequence state
  tmt_clr_state_e next_state; // next value of state
  logic           next_flag;  // next value of flag_out

  // a trigger always wins over a clear in the same cycle
  always_comb
  begin
    next_flag  = flag_out;
    next_state = state;
    case (state)
      TMT_IDLE:
      begin
        if (rd_in && flag_out && !set_in)
          next_state = TMT_ARMED;
      end
      TMT_ARMED:
      begin
        if (set_in)
          next_state = TMT_IDLE;                 // see RULE_04
        else if (wr_in)
        begin
          next_state = TMT_IDLE;
          if (!wbit_in)                          // see RULE_03
            next_flag = 1'b0;                    // see RULE_02
        end
      end
      default:
        next_state = TMT_IDLE;
    endcase
    if (set_in)
      next_flag = 1'b1;                          // see RULE_01
  end

  // flag and sequence registers
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      flag_out <= 1'b0;
      state    <= TMT_IDLE;
    end
    else
    begin
      flag_out <= next_flag;
      state    <= next_state;
    end
  end

  // flag never rises without a trigger
  flag_rise_cause_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_03
    $rose(flag_out) |-> $past(set_in))
    else $error("flag rose without a trigger");

  // flag falls only after read then write zero
  flag_fall_seq_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_02
    $fell(flag_out) |-> $past(wr_in) && !$past(wbit_in) && $past(state == TMT_ARMED))
    else $error("flag cleared outside the sequence");

  // trigger between read and write keeps flag
  abort_keeps_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_04
    (state == TMT_ARMED && set_in) ##1 (wr_in && !wbit_in && !set_in) |=> flag_out)
    else $error("flag cleared after aborted sequence");
endmodule
`default_nettype wire

// ==== logic/tmt_trigger_gen.sv ====
/*
  timer trigger generation: trigger control register, trigger
  sources, hardware trigger output and a small interrupt unit.
  assumes count, initial value and match levels come from the rest of
  the timer on clk_in, and a bus master that never overlaps strobes.
*/
// The placing of the registers and the plain strobed port were left to the implementer.
`default_nettype none
`include "tmt_consts.svh"
module tmt_trigger_gen #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  // register bus
  input  wire tmt_pkg::tmt_bus_req_s bus_in,
  output logic       [31:0]          rdata_out,
  // timer state
  input  wire logic  [CNT_W-1:0]     count_in,
  input  wire logic  [CNT_W-1:0]     init_value_in,
  input  wire logic  [`TMT_NUM_CHAN-1:0] chan_match_in,
  // trigger and interrupt
  output logic                       trigger_out,
  output logic                       irq_out
);
  import tmt_pkg::*;

  // channel enable vector in channel order from the control bits
  function automatic logic [`TMT_TRIG_CHAN-1:0] chan_enables(input logic [6:0] c);
    logic [`TMT_TRIG_CHAN-1:0] e;
    e    = '0;
    e[0] = c[`TMT_BIT_CH0_EN];                   // see RULE_13
    e[1] = c[`TMT_BIT_CH1_EN];                   // see RULE_06
    e[2] = c[`TMT_BIT_CH2_EN];                   // see RULE_13
    e[3] = c[`TMT_BIT_CH3_EN];                   // see RULE_13
    e[4] = c[`TMT_BIT_CH4_EN];                   // see RULE_08
    e[5] = c[`TMT_BIT_CH5_EN];                   // see RULE_07
    return e;
  endfunction

  // address match helper, used by every strobe decode
  function automatic logic hit(input logic [`TMT_ADDR_W-1:0] a,
                               input logic [`TMT_ADDR_W-1:0] off);
    return a == off;
  endfunction

  // bus decode
  logic wr_trig;    // write to trigger register
  logic rd_trig;    // read of trigger register
  logic wr_irq_clr; // write to interrupt clear
  logic wr_irq_en;  // write to interrupt enable

  assign wr_trig    = bus_in.wr && hit(bus_in.addr, `TMT_OFF_TRIG);
  assign rd_trig    = bus_in.rd && hit(bus_in.addr, `TMT_OFF_TRIG);
  assign wr_irq_clr = bus_in.wr && hit(bus_in.addr, `TMT_OFF_IRQ_CLR);
  assign wr_irq_en  = bus_in.wr && hit(bus_in.addr, `TMT_OFF_IRQ_EN);

  // control bits 6..0 of the trigger register
  logic [6:0] ctrl;      // init enable and channel enables
  logic [6:0] next_ctrl; // next value of ctrl

  // only bits 6..0 are stored, so reserved bits cannot steer anything
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_trig)
      next_ctrl = bus_in.wdata[6:0];             // see RULE_10
  end

  // control register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ctrl <= `TMT_RST_CTRL;
    else
      ctrl <= next_ctrl;
  end

  // trigger sources
  logic [`TMT_NUM_CHAN-1:0]  chan_rise; // match rises, all channels
  logic [0:0]                init_rise; // initial-value match rise
  logic [0:0]                init_eq;   // counter equals initial value
  logic [`TMT_TRIG_CHAN-1:0] chan_en;   // per-channel enables
  logic                      chan_trig; // any enabled channel trigger
  logic                      init_trig; // initialization trigger

  assign init_eq = count_in == init_value_in;

  // one pulse per match even when the counter is prescaled
  tmt_edge_det #(
    .W (`TMT_NUM_CHAN)
  ) u_chan_edge (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .level_in (chan_match_in),
    .rise_out (chan_rise)
  );

  // same treatment for the initial-value comparison
  tmt_edge_det #(
    .W (1)
  ) u_init_edge (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .level_in (init_eq),
    .rise_out (init_rise)
  );

  assign chan_en = chan_enables(ctrl);
  // channels 6 and 7 are simply not wired into the or
  assign chan_trig = |(chan_rise[`TMT_TRIG_CHAN-1:0] & chan_en);     // see RULE_09, RULE_11, RULE_12
  assign init_trig = init_rise[0] && ctrl[`TMT_BIT_INIT_EN];         // see RULE_05

  // trigger output
  logic next_trigger; // next value of trigger_out

  // coincident sources merge into one pulse; that is the trade for a single wire
  always_comb
  begin
    next_trigger = chan_trig || init_trig;       // see RULE_14
  end

  // trigger output register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      trigger_out <= 1'b0;
    else
      trigger_out <= next_trigger;
  end

  // sticky channel trigger flag
  logic flag; // channel trigger flag

  tmt_trig_flag u_flag (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .set_in   (chan_trig),
    .rd_in    (rd_trig),
    .wr_in    (wr_trig),
    .wbit_in  (bus_in.wdata[`TMT_BIT_FLAG]),
    .flag_out (flag)
  );

  // interrupt unit
  logic [1:0] irq_stat;      // sticky event bits
  logic [1:0] irq_en;        // enable mask
  logic [1:0] irq_evt;       // events this cycle
  logic [1:0] next_irq_stat; // next value of irq_stat
  logic [1:0] next_irq_en;   // next value of irq_en
  logic       next_irq;      // next value of irq_out

  // a clear in the same cycle as an event loses
  always_comb
  begin
    irq_evt                = '0;
    irq_evt[`TMT_IRQ_CHAN] = chan_trig;
    irq_evt[`TMT_IRQ_INIT] = init_trig;
    next_irq_stat = irq_stat;
    if (wr_irq_clr)
      next_irq_stat = next_irq_stat & ~bus_in.wdata[1:0];
    next_irq_stat = next_irq_stat | irq_evt;
    next_irq_en   = irq_en;
    if (wr_irq_en)
      next_irq_en = bus_in.wdata[1:0];
    next_irq      = |(next_irq_stat & next_irq_en);
  end

  // interrupt registers
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      irq_stat <= `TMT_RST_IRQ;
      irq_en   <= `TMT_RST_IRQ;
      irq_out  <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_en   <= next_irq_en;
      irq_out  <= next_irq;
    end
  end

  // read data
  logic [31:0] next_rdata; // next value of rdata_out

  // data stand only in the cycle after the strobe; unmapped reads give zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        `TMT_OFF_TRIG:
          next_rdata = {24'h00_0000, flag, ctrl};   // see RULE_10
        `TMT_OFF_IRQ_STAT:
          next_rdata = {30'h0000_0000, irq_stat};
        `TMT_OFF_IRQ_EN:
          next_rdata = {30'h0000_0000, irq_en};
        default:
          next_rdata = 32'h0000_0000;               // clear register is write-only
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_out <= 32'h0000_0000;
    else
      rdata_out <= next_rdata;
  end

  // enabled channel match yields a pulse next cycle
  chan_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_09
    (|(chan_rise[`TMT_TRIG_CHAN-1:0] & chan_en)) |=> trigger_out)
    else $error("enabled channel match gave no trigger");

  // channel 1 enable bit steers channel 1
  chan1_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_06
    (chan_rise == 8'h02 && !init_trig) |=> (trigger_out == $past(ctrl[`TMT_BIT_CH1_EN])))
    else $error("channel 1 trigger not gated by bit 5");

  // channel 5 enable bit steers channel 5
  chan5_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_07
    (chan_rise == 8'h20 && !init_trig) |=> (trigger_out == $past(ctrl[`TMT_BIT_CH5_EN])))
    else $error("channel 5 trigger not gated by bit 3");

  // channel 4 enable bit steers channel 4
  chan4_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_08
    (chan_rise == 8'h10 && !init_trig) |=> (trigger_out == $past(ctrl[`TMT_BIT_CH4_EN])))
    else $error("channel 4 trigger not gated by bit 2");

  // channels 0, 3 and 2 sit at bits 4, 1, 0
  low_chan_map_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_13
    chan_en[0] == ctrl[4] && chan_en[3] == ctrl[1] && chan_en[2] == ctrl[0])
    else $error("low channel enable mapping wrong");

  // channels 6 and 7 alone never trigger
  high_chan_mute_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_11
    (chan_rise[5:0] == 6'h00 && !init_trig) |=> !trigger_out)
    else $error("channel 6 or 7 produced a trigger");

  // initialization trigger follows its enable
  init_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_05
    (init_rise[0] && chan_rise == 8'h00) |=> (trigger_out == $past(ctrl[`TMT_BIT_INIT_EN])))
    else $error("initialization trigger not gated by bit 6");

  // steady match gives a single-cycle pulse
  single_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_14
    (trigger_out && !chan_trig && !init_trig) |=> !trigger_out)
    else $error("trigger wider than one cycle");

  // channel trigger sets the flag next cycle
  flag_set_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_01
    chan_trig |=> flag && rdata_out[`TMT_BIT_FLAG] == $past(rd_trig && flag))
    else $error("channel trigger did not set the flag");

  // reserved bits always read zero
  reserved_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_10
    rd_trig |=> rdata_out[31:8] == 24'h00_0000)
    else $error("reserved trigger bits read non-zero");

  // two separated enabled matches give two pulses
  multi_trig_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_12
    (chan_trig ##2 chan_trig) |-> ##1 trigger_out ##0 $past(trigger_out, 2))
    else $error("second channel trigger lost");

  // channel 0 enable bit steers channel 0
  chan0_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_09
    (chan_rise == 8'h01 && !init_trig) |=> (trigger_out == $past(ctrl[`TMT_BIT_CH0_EN])))
    else $error("channel 0 trigger not gated by its enable");

  // channel 2 enable bit steers channel 2
  chan2_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_09
    (chan_rise == 8'h04 && !init_trig) |=> (trigger_out == $past(ctrl[`TMT_BIT_CH2_EN])))
    else $error("channel 2 trigger not gated by its enable");

  // channel 3 enable bit steers channel 3
  chan3_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_09
    (chan_rise == 8'h08 && !init_trig) |=> (trigger_out == $past(ctrl[`TMT_BIT_CH3_EN])))
    else $error("channel 3 trigger not gated by its enable");

  // disabled initialization source stays quiet
  init_only_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_05
    (!ctrl[`TMT_BIT_INIT_EN] && !chan_trig) |=> !trigger_out)
    else $error("trigger without an enabled source");

  // initialization trigger alone leaves a clear flag clear
  init_no_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_01
    (init_trig && !chan_trig && !flag) |=> !flag)
    else $error("initialization trigger set the channel flag");

  // matches on channels 6 and 7 never reach the flag
  high_chan_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_11
    (chan_rise[5:0] == 6'h00 && !flag) |=> !flag)
    else $error("flag set without a low channel match");

  // writing one to the flag bit changes nothing
  flag_write_one_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_03
    (wr_trig && bus_in.wdata[`TMT_BIT_FLAG] && !chan_trig) |=> (flag == $past(flag)))
    else $error("write of one changed the flag");

  // only bits 6..0 of a trigger write land
  ctrl_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_10
    wr_trig |=> (ctrl == $past(bus_in.wdata[6:0])))
    else $error("control bits differ from the write");

  // control bits move only on a trigger write
  ctrl_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_10
    !wr_trig |=> $stable(ctrl))
    else $error("control bits changed without a write");

  // trigger read returns flag and control bits
  trig_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_10
    rd_trig |=> (rdata_out[7:0] == {$past(flag), $past(ctrl)}))
    else $error("trigger register read wrong");

  // read data are zero outside the answer cycle
  rdata_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_10
    !bus_in.rd |=> (rdata_out == 32'h0000_0000))
    else $error("read data outside the answer cycle");

  // channel trigger marks its interrupt status
  irq_chan_evt_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_01
    chan_trig |=> irq_stat[`TMT_IRQ_CHAN])
    else $error("channel trigger missed its status bit");

  // initialization trigger marks its interrupt status
  irq_init_evt_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_05
    init_trig |=> irq_stat[`TMT_IRQ_INIT])
    else $error("initialization trigger missed its status bit");

  // clear write drops the chosen status bits when no event races it
  irq_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_01
    (wr_irq_clr && !chan_trig && !init_trig) |=> ((irq_stat & $past(bus_in.wdata[1:0])) == 2'h0))
    else $error("status bits survived a clear");

  // interrupt line follows enabled status
  irq_level_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // see RULE_01
    irq_out == |(irq_stat & irq_en))
    else $error("interrupt line disagrees with status");
endmodule
`default_nettype wire

// ==== tb/tmt_trig_sink.sv ====
/*
  model of an on-chip module that takes the hardware trigger.
  assumes the trigger is synchronous to clk_in and active high.
*/
`default_nettype none
module tmt_trig_sink (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // trigger from the block
  input  wire logic trig_in,
  // pulse and over-long pulse counts
  output int        pulses_out,
  output int        wide_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last; // trigger one cycle ago

  // a receiver counts edges, so a pulse two cycles long must be flagged
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      last       <= 1'b0;
      pulses_out <= 0;
      wide_out   <= 0;
    end
    else
    begin
      last <= trig_in;
      if (trig_in && !last)
        pulses_out <= pulses_out + 1;
      if (trig_in && last)
        wide_out <= wide_out + 1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tmt_trigger_gen_tb.sv ====
/*
  self-checking bench of the timer trigger generation block.
  assumes tmt_pkg and tmt_consts.svh are compiled before this file.
*/
`default_nettype none
`include "tmt_consts.svh"
module tmt_trigger_gen_tb;
  import tmt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // one table row: control word, source (8 = initial value), pulse
  typedef struct {
    logic [31:0] ctrl;
    int          src;
    logic        trig;
  } tmt_row_s;

  logic         clk_in;
  logic         nrst_in;
  tmt_bus_req_s bus;
  logic [31:0]  rdata;
  logic [15:0]  count;
  logic [15:0]  init_val;
  logic [7:0]   match;
  logic         trig;
  logic         irq;
  int           pulses;
  int           wide;
  int           n_errors;
  int           checked;
  logic [31:0]  d;
  logic         t;
  int           n0;
  tmt_row_s     rows [17];

  tmt_trigger_gen u_dut (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .bus_in        (bus),
    .rdata_out     (rdata),
    .count_in      (count),
    .init_value_in (init_val),
    .chan_match_in (match),
    .trigger_out   (trig),
    .irq_out       (irq)
  );

  tmt_trig_sink u_sink (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .trig_in    (trig),
    .pulses_out (pulses),
    .wide_out   (wide)
  );

  // 200 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // one-cycle match level, then the trigger one cycle later
  task automatic pulse(input int src, output logic tv);
    @(posedge clk_in);
    if (src == 8)
      count <= init_val;
    else
      match[src] <= 1'b1;
    @(posedge clk_in);
    count <= 16'h0005;
    match <= 8'h00;
    #1 tv = trig;
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, far beyond the couple of hundred cycles of the tests
  initial
  begin
    #100000;
    n_errors++;
    conclude();
  end

  initial
  begin
    n_errors = 0;
    checked = 0;
    nrst_in = 1'b0;
    bus = '0;
    count = 16'h0005;
    init_val = 16'h0009;
    match = 8'h00;
    rows = '{'{32'h0000_0010, 0, 1'b1}, '{32'h0000_0020, 1, 1'b1}, '{32'h0000_0001, 2, 1'b1},
             '{32'h0000_0002, 3, 1'b1}, '{32'h0000_0004, 4, 1'b1}, '{32'h0000_0008, 5, 1'b1},
             '{32'h0000_002f, 0, 1'b0}, '{32'h0000_003f, 6, 1'b0}, '{32'h0000_003f, 7, 1'b0},
             '{32'h0000_0040, 8, 1'b1}, '{32'h0000_003f, 8, 1'b0}, '{32'hffff_ff90, 0, 1'b1},
             '{32'h0000_001f, 1, 1'b0}, '{32'h0000_0037, 5, 1'b0}, '{32'h0000_003b, 4, 1'b0},
             '{32'h0000_003e, 2, 1'b0}, '{32'h0000_003d, 3, 1'b0}};
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    // every source, enabled and disabled, then a flag clear
    foreach (rows[i])
    begin
      wr(`TMT_OFF_TRIG, rows[i].ctrl);
      pulse(rows[i].src, t);
      chk_bit("trigger", rows[i].trig, t);
      rd(`TMT_OFF_TRIG, d);
      chk_reg("trig_reg", {24'h0, rows[i].trig && rows[i].src < 8, rows[i].ctrl[6:0]}, d);
      wr(`TMT_OFF_TRIG, rows[i].ctrl & 32'h0000_007f);
    end
    // a new trigger between read and write keeps the flag
    wr(`TMT_OFF_TRIG, 32'h0000_0010);
    pulse(0, t);
    rd(`TMT_OFF_TRIG, d);
    // trigger lands right before the clearing write, the tightest case
    @(posedge clk_in);
    match[0] <= 1'b1;
    @(posedge clk_in);
    match <= 8'h00;
    bus.addr <= `TMT_OFF_TRIG;
    bus.wdata <= 32'h0000_0010;
    bus.wr <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
    rd(`TMT_OFF_TRIG, d);
    chk_bit("flag_abort", 1'b1, d[7]);
    // writing one, or zero without a read, keeps the flag
    wr(`TMT_OFF_TRIG, 32'h0000_0090);
    wr(`TMT_OFF_TRIG, 32'h0000_0010);
    rd(`TMT_OFF_TRIG, d);
    chk_bit("flag_kept", 1'b1, d[7]);
    wr(`TMT_OFF_TRIG, 32'h0000_0010);
    rd(`TMT_OFF_TRIG, d);
    chk_bit("flag_clear", 1'b0, d[7]);
    // two channels in one period give two pulses
    wr(`TMT_OFF_TRIG, 32'h0000_003f);
    n0 = pulses;
    pulse(0, t);
    pulse(3, t);
    repeat (2) @(posedge clk_in);
    chk_reg("pulses", 32'(pulses - n0), 32'h0000_0002);
    // interrupt: raise, read, clear, mask
    wr(`TMT_OFF_IRQ_CLR, 32'h0000_0003);
    wr(`TMT_OFF_IRQ_EN, 32'h0000_0001);
    pulse(1, t);
    chk_bit("irq_on", 1'b1, irq);
    rd(`TMT_OFF_IRQ_STAT, d);
    chk_reg("irq_stat", 32'h0000_0001, d);
    rd(`TMT_OFF_IRQ_CLR, d);
    chk_reg("irq_clr_rd", 32'h0000_0000, d);
    rd(8'h44, d);
    chk_reg("unmapped", 32'h0000_0000, d);
    wr(`TMT_OFF_IRQ_CLR, 32'h0000_0001);
    rd(`TMT_OFF_IRQ_STAT, d);
    chk_reg("irq_stat_clr", 32'h0000_0000, d);
    chk_bit("irq_off", 1'b0, irq);
    wr(`TMT_OFF_IRQ_EN, 32'h0000_0002);
    pulse(1, t);
    chk_bit("irq_masked", 1'b0, irq);
    wr(`TMT_OFF_TRIG, 32'h0000_0040);
    pulse(8, t);
    rd(`TMT_OFF_IRQ_STAT, d);
    chk_reg("irq_stat_both", 32'h0000_0003, d);
    chk_bit("irq_init", 1'b1, irq);
    chk_reg("wide", 32'(wide), 32'h0000_0000);
    // reset in mid-run clears everything
    @(posedge clk_in);
    nrst_in <= 1'b0;
    #1 chk_bit("irq_rst", 1'b0, irq);
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(`TMT_OFF_TRIG, d);
    chk_reg("trig_rst", 32'h0000_0000, d);
    rd(`TMT_OFF_IRQ_EN, d);
    chk_reg("en_rst", 32'h0000_0000, d);
    conclude();
  end
endmodule
`default_nettype wire
